// [hw/sptr_defines.svh]
// Constants of the serial port transmit-ready block
`ifndef SPTR_DEFINES_SVH
`define SPTR_DEFINES_SVH

// ==========================================================
// Widths and depths
`define SPTR_HALF_W        16
`define SPTR_FIFO_DEPTH    16
`define SPTR_FIFO_AW       4

// ==========================================================
// Transmit event source select codes
`define SPTR_IRQ_SEL_W     2
`define SPTR_IRQ_SEL_READY 2'h0
`define SPTR_IRQ_SEL_MOVE  2'h1

// ==========================================================
// Reset values
`define SPTR_HALF_RESET    16'h0000

`endif

// [hw/sptr_fifo.sv]
// Parameterised word FIFO with valid/ready on both sides
`timescale 1ns/1ns
`include "sptr_defines.svh"

module sptr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = `SPTR_FIFO_DEPTH,
  parameter int AW    = `SPTR_FIFO_AW
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             resetn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_ptr_q;
  logic [AW:0]      wr_ptr_d;
  logic [AW:0]      rd_ptr_q;
  logic [AW:0]      rd_ptr_d;
  logic             push;
  logic             pop;

  // ==========================================================
  // Full and empty from pointers with a wrap bit
  assign in_ready  = !((wr_ptr_q[AW] != rd_ptr_q[AW]) &&
                       (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]));
  assign out_valid = (wr_ptr_q != rd_ptr_q);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

  // Next pointer values
  always_comb begin
    wr_ptr_d = wr_ptr_q;
    rd_ptr_d = rd_ptr_q;
    if (push) begin
      wr_ptr_d = wr_ptr_q + {{AW{1'b0}}, 1'b1};
    end
    if (pop) begin
      rd_ptr_d = rd_ptr_q + {{AW{1'b0}}, 1'b1};
    end
  end

  // Pointer registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      wr_ptr_q <= wr_ptr_d;
      rd_ptr_q <= rd_ptr_d;
    end
  end

  // Storage, written only on a push
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data;
    end
  end

endmodule : sptr_fifo

// [hw/sptr_pkg.sv]
// Types shared by the serial port transmit-ready block
`include "sptr_defines.svh"

package sptr_pkg;

  // ==========================================================
  // One transmit word, high half above low half
  typedef struct packed {
    logic [`SPTR_HALF_W-1:0] high;
    logic [`SPTR_HALF_W-1:0] low;
  } sptr_word_type;

  // ==========================================================
  // Holding stage states, one-hot
  typedef enum logic [2:0] {
    SPTR_ST_READY  = 3'h1,
    SPTR_ST_LOADED = 3'h2,
    SPTR_ST_STUCK  = 3'h4
  } sptr_state_type;

endpackage : sptr_pkg

// [hw/sptr_top.sv]
// Transmit holding stage and ready flag of the buffered serial port
// Contract
// - A write to the low holding register clears the ready flag to zero.
// - Moving held data into the shift stage sets the ready flag to one.
// - Set and clear in one cycle leave the flag clear; new data dropped.
// - After that collision the flag stays zero until another low register write.
// - Later writes after a collision behave normally again.
// - The transmit event output can be chosen to follow the ready flag.
`timescale 1ns/1ns
`include "sptr_defines.svh"

module sptr_top (
  // Clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         resetn,
  // Bus writes into the holding registers
  input  wire logic                         tx_hold_low_wr,
  input  wire logic                         tx_hold_high_wr,
  input  wire logic [`SPTR_HALF_W-1:0]      tx_hold_wdata,
  // Configuration
  input  wire logic [`SPTR_IRQ_SEL_W-1:0]   tx_irq_source_select,
  // Status towards the bus controllers
  output logic                              tx_ready_flag,
  output logic                              tx_event_irq,
  output logic                              tx_stuck,
  // Words towards the serialiser
  output logic                              tx_shift_valid,
  input  wire logic                         tx_shift_ready,
  output sptr_pkg::sptr_word_type           tx_shift_low
);

  sptr_pkg::sptr_state_type state_q;
  sptr_pkg::sptr_state_type state_d;
  sptr_pkg::sptr_word_type  hold_q;
  sptr_pkg::sptr_word_type  hold_d;
  logic                     irq_q;
  logic                     irq_d;
  logic                     fifo_in_ready;
  logic                     move;
  logic                     hold_full;

  // ==========================================================
  // Transfer from holding stage into the shift FIFO
  assign hold_full = (state_q == sptr_pkg::SPTR_ST_LOADED);
  assign move      = hold_full && fifo_in_ready;

  // ==========================================================
  // Holding stage state and data
  always_comb begin
    state_d = state_q;
    hold_d  = hold_q;
    if (tx_hold_high_wr) begin
      hold_d.high = tx_hold_wdata;
    end
    case (state_q)
      sptr_pkg::SPTR_ST_READY: begin
        if (tx_hold_low_wr) begin
          hold_d.low = tx_hold_wdata;
          state_d    = sptr_pkg::SPTR_ST_LOADED;
        end
      end
      sptr_pkg::SPTR_ST_LOADED: begin
        if (move && tx_hold_low_wr) begin
          hold_d.high = hold_q.high;
          state_d     = sptr_pkg::SPTR_ST_STUCK;
        end else if (move) begin
          state_d = sptr_pkg::SPTR_ST_READY;
        end else if (tx_hold_low_wr) begin
          hold_d.low = tx_hold_wdata;
        end
      end
      sptr_pkg::SPTR_ST_STUCK: begin
        if (tx_hold_low_wr) begin
          hold_d.low = tx_hold_wdata;
          state_d    = sptr_pkg::SPTR_ST_LOADED;
        end
      end
      default: begin
        state_d = sptr_pkg::SPTR_ST_READY;
      end
    endcase
  end

  // State and holding registers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= sptr_pkg::SPTR_ST_READY;
      hold_q  <= '{high: `SPTR_HALF_RESET, low: `SPTR_HALF_RESET};
    end else begin
      state_q <= state_d;
      hold_q  <= hold_d;
    end
  end

  // ==========================================================
  // Flag outputs
  assign tx_ready_flag = (state_q == sptr_pkg::SPTR_ST_READY);
  assign tx_stuck      = (state_q == sptr_pkg::SPTR_ST_STUCK);

  // Transmit event source choice
  always_comb begin
    case (tx_irq_source_select)
      `SPTR_IRQ_SEL_READY: irq_d = (state_d == sptr_pkg::SPTR_ST_READY);
      `SPTR_IRQ_SEL_MOVE:  irq_d = move;
      default:             irq_d = 1'b0;
    endcase
  end

  // Event register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_q <= 1'b1;
    end else begin
      irq_q <= irq_d;
    end
  end

  assign tx_event_irq = irq_q;

  // ==========================================================
  // Shift-side FIFO, stalled by the serialiser
  sptr_fifo #(
    .WIDTH ($bits(sptr_pkg::sptr_word_type)),
    .DEPTH (`SPTR_FIFO_DEPTH),
    .AW    (`SPTR_FIFO_AW)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .resetn    (resetn),
    .in_valid  (hold_full),
    .in_ready  (fifo_in_ready),
    .in_data   (hold_q),
    .out_valid (tx_shift_valid),
    .out_ready (tx_shift_ready),
    .out_data  (tx_shift_low)
  );

endmodule : sptr_top

// [tb/sptr_sink.sv]
// Serialiser model that takes words from the FIFO head
`timescale 1ns/1ns

module sptr_sink (
  // Clock and reset
  input wire logic                     clk_sys,
  input wire logic                     resetn,
  // Word stream and stall control
  input wire logic                     stall,
  input wire logic                     valid,
  output logic                         ready,
  input wire sptr_pkg::sptr_word_type  word
);
  sptr_pkg::sptr_word_type got[$];
  // Takes one word per cycle unless stalled
  assign ready = resetn && !stall;
  always @(posedge clk_sys) if (valid && ready) got.push_back(word);
endmodule : sptr_sink

// [tb/sptr_top_assertions.sv]
// Checker of the transmit-ready handshake, bound to the top ports
`timescale 1ns/1ns
`include "sptr_defines.svh"

module sptr_checker (
  // Clock and reset
  input wire logic                        clk_sys,
  input wire logic                        resetn,
  // Watched ports
  input wire logic                        tx_hold_low_wr,
  input wire logic                        tx_hold_high_wr,
  input wire logic [`SPTR_IRQ_SEL_W-1:0]  tx_irq_source_select,
  input wire logic                        tx_ready_flag,
  input wire logic                        tx_event_irq,
  input wire logic                        tx_stuck,
  input wire logic                        tx_shift_valid
);
  // ==========================================================
  // Holding stage steps
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence loaded_s;
    !tx_ready_flag && !tx_stuck;
  endsequence
  sequence move_s;
    loaded_s ##0 !tx_hold_low_wr && !tx_shift_valid;
  endsequence
  sequence bump_s;
    loaded_s ##0 tx_hold_low_wr && !tx_shift_valid;
  endsequence
  wclear_a: assert property (tx_ready_flag && tx_hold_low_wr |=> !tx_ready_flag)
    else $error("flag kept high after low write");
  move_set_a: assert property (move_s |=> tx_ready_flag)
    else $error("flag not set after move");
  collide_a: assert property (bump_s |=> !tx_ready_flag && tx_stuck)
    else $error("collision not held");
  stuck_hold_a: assert property (tx_stuck && !tx_hold_low_wr |=> tx_stuck && !tx_ready_flag)
    else $error("stuck state left without write");
  stuck_leave_a: assert property (tx_stuck && tx_hold_low_wr |=> loaded_s)
    else $error("write after collision not taken");
  high_keep_a: assert property (
    tx_ready_flag && tx_hold_high_wr && !tx_hold_low_wr |=> tx_ready_flag)
    else $error("high write moved the flag");
  irq_follow_a: assert property (
    tx_irq_source_select == `SPTR_IRQ_SEL_READY &&
    $past(tx_irq_source_select) == `SPTR_IRQ_SEL_READY |-> tx_event_irq == tx_ready_flag)
    else $error("event does not follow flag");
  irq_pulse_a: assert property (
    tx_irq_source_select == `SPTR_IRQ_SEL_MOVE && $rose(tx_ready_flag) |-> tx_event_irq)
    else $error("no event pulse after move");
endmodule : sptr_checker

bind sptr_top sptr_checker sptr_checker_inst (.clk_sys, .resetn, .tx_hold_low_wr,
  .tx_hold_high_wr, .tx_irq_source_select, .tx_ready_flag, .tx_event_irq, .tx_stuck,
  .tx_shift_valid);

// [tb/sptr_top_tb.sv]
// Self-checking bench of the transmit-ready block
`timescale 1ns/1ns

module sptr_top_tb;
  logic        clk_sys = 0, resetn = 0, lo = 0, hi = 0, stall = 0, sv, sr, rdy, irq, stk;
  logic [15:0] wd = 16'h0000;
  logic [1:0]  sel = 2'h0;
  int          bad_count = 0, n_checks = 0;
  sptr_pkg::sptr_word_type sw;
  // ==========================================================
  // Clock, design and serialiser model
  always #25 clk_sys = ~clk_sys;
  sptr_top sptr_top_inst (.clk_sys, .resetn, .tx_hold_low_wr(lo), .tx_hold_high_wr(hi),
    .tx_hold_wdata(wd), .tx_irq_source_select(sel), .tx_ready_flag(rdy), .tx_event_irq(irq),
    .tx_stuck(stk), .tx_shift_valid(sv), .tx_shift_ready(sr), .tx_shift_low(sw));
  sptr_sink sptr_sink_inst (.clk_sys, .resetn, .stall, .valid(sv), .ready(sr), .word(sw));
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // One write strobe for one cycle, called at a falling edge
  task wr(input logic h, input logic [15:0] d);
    wd = d;
    hi = h;
    lo = !h;
    @(negedge clk_sys);
    hi = 0;
    lo = 0;
  endtask : wr
  task wait_rdy;
    for (int k = 0; k < 8 && rdy !== 1'b1; k++) @(negedge clk_sys);
  endtask : wait_rdy
  task t_basic(input logic [1:0] s);
    sel = s;
    @(negedge clk_sys);
    sptr_sink_inst.got.delete();
    wr(1, 16'hA5C3);
    chk(rdy, 1);
    @(negedge clk_sys);
    wr(0, 16'h5A0F);
    chk(rdy, 0);
    @(negedge clk_sys);
    chk({rdy, irq}, {1'b1, s < 2'h2});
    @(negedge clk_sys);
    chk(irq, s == 2'h0);
    chk(sptr_sink_inst.got[0], 32'hA5C35A0F);
  endtask : t_basic
  task t_collide;
    sptr_sink_inst.got.delete();
    wd = 16'h1111;
    lo = 1;
    @(negedge clk_sys);
    wd = 16'h2222;
    @(negedge clk_sys);
    lo = 0;
    chk({stk, rdy}, 2'b10);
    repeat (20) @(negedge clk_sys);
    chk({stk, rdy}, 2'b10);
    wr(0, 16'h3333);
    chk(stk, 0);
    repeat (3) @(negedge clk_sys);
    chk(rdy, 1);
    chk(sptr_sink_inst.got.size(), 2);
    chk({sptr_sink_inst.got[0].low, sptr_sink_inst.got[1].low}, 32'h11113333);
  endtask : t_collide
  task t_full;
    stall = 1;
    sptr_sink_inst.got.delete();
    for (int i = 0; i < 17; i++) begin
      wait_rdy();
      chk(rdy, 1);
      wr(0, 16'(i));
    end
    repeat (8) @(negedge clk_sys);
    chk(rdy, 0);
    stall = 0;
    repeat (30) @(negedge clk_sys);
    chk({rdy, sv}, 2'b10);
    chk(sptr_sink_inst.got.size(), 17);
    chk(sptr_sink_inst.got[16].low, 16);
  endtask : t_full
  // Reset in mid-run while a word is held: ready again at once and after release
  task t_reset;
    wr(0, 16'h7777);
    resetn = 0;
    @(negedge clk_sys);
    chk({rdy, stk, sv, irq}, 4'b1001);
    resetn = 1;
    @(negedge clk_sys);
    chk({rdy, stk, sv, irq}, 4'b1001);
    @(negedge clk_sys);
    chk({rdy, stk, sv, irq}, 4'b1001);
  endtask : t_reset
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // Watchdog against a hang
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_sys);
    resetn = 1;
    chk({rdy, stk, sv, irq}, 4'b1001);
    for (int s = 3; s >= 0; s--) t_basic(2'(s));
    t_collide();
    t_full();
    t_reset();
    close_out();
  end
endmodule : sptr_top_tb
